// file: rtl/microstep_translator.sv
// Purpose: step translator, position counter and coil current select
// Assumes: step and direction pins are asynchronous to ref_clk
// Notes:   registers on a plain port, read data one cycle after strobe
//
// Function
// (RULE1) position indexes the circular table, codes 0..4 step by 1,2,4,8,16.
// (RULE2) direction comes from the sense pin together with a control bit.
// (RULE3) the control bit exclusive-ors the pin, inverting the direction.
// (RULE4) each active step edge moves one stride up or down.
// (RULE5) a polarity bit picks rising or falling step edges.
// (RULE6) position is readable as 7 bits in 1/32 units in any resolution.
// (RULE7) readable position updates right after each step trigger.
// (RULE8) a new resolution takes effect on the next step pulse only.
// (RULE9) going finer keeps the current position, already on the finer grid.
// (RULE10) going coarser on a shared position steps without offset.
// (RULE11) going coarser off-grid steps by the new stride, keeping an offset.
// (RULE12) position wraps modulo 128.
// (RULE13) reset gives 1/32 stepping at position zero.
// (RULE14) codes 5 and 6 use the square table.
`timescale 1ns/100ps
module microstep_translator
   import translator_pkg::*;
(
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rstn,
   // motion pins
   input  wire logic                 step_pulse_in,
   input  wire logic                 dir_pin,
   // register port
   input  wire logic [ADDR_W-1:0]    addr,
   input  wire logic [DATA_W-1:0]    wdata,
   input  wire logic                 wr_stb,
   input  wire logic                 rd_stb,
   output logic      [DATA_W-1:0]    rdata,
   // coil currents and position
   output logic signed [CUR_W-1:0]   coil_x,
   output logic signed [CUR_W-1:0]   coil_y,
   output logic      [POS_W-1:0]     translator_position
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_STEP = 2'b01
   } phase_t;

   typedef struct packed {
      logic [1:0] step_sync;
      logic [1:0] dir_sync;
      logic       step_prev;
      logic [2:0] step_resolution_sel;  // programmed
      logic [2:0] active_res;           // in use
      logic       rotation_sense_bit;
      logic       step_edge_polarity;
      logic [6:0] pos;
      logic [7:0] rdata;
      logic signed [10:0] cx;
      logic signed [10:0] cy;
      phase_t     phase;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic signed [10:0] map_x;
   logic signed [10:0] map_y;
   logic [6:0] next_pos;

   // stride in 1/32 units for a resolution code
   function automatic logic [6:0] stride_of(input logic [2:0] res);
      case (res)
         3'h0:    stride_of = 7'h01;
         3'h1:    stride_of = 7'h02;
         3'h2:    stride_of = 7'h04;
         3'h3:    stride_of = 7'h08;
         3'h4:    stride_of = 7'h10;
         3'h5:    stride_of = 7'h10;
         default: stride_of = 7'h20;
      endcase
   endfunction

   // square table when the in-use code is 5 or 6
   function automatic logic is_square(input logic [2:0] res);
      is_square = (res == RES_HALF_SQ) || (res == RES_FULL);
   endfunction

   // table lookup on the position about to be registered
   coil_current_map u_map (
      .pos    (next_pos),
      .square (is_square(st_next.active_res)),
      .cur_x  (map_x),
      .cur_y  (map_y)
   );

   logic trig;
   logic dir_up;
   logic [6:0] stride;

   // next-state logic
   always_comb begin
      st_next = st_reg;
      st_next.step_sync = {st_reg.step_sync[0], step_pulse_in};
      st_next.dir_sync = {st_reg.dir_sync[0], dir_pin};
      st_next.step_prev = st_reg.step_sync[1];
      // polarity 0 rising, 1 falling
      trig = st_reg.step_edge_polarity ?
             (st_reg.step_prev & ~st_reg.step_sync[1]) :
             (~st_reg.step_prev & st_reg.step_sync[1]);          // see (RULE5)
      dir_up = st_reg.dir_sync[1] ^ st_reg.rotation_sense_bit;   // see (RULE2) see (RULE3)
      stride = stride_of(st_reg.step_resolution_sel);
      next_pos = st_reg.pos;
      st_next.phase = ST_IDLE;
      if (trig) begin
         // pending code taken up only now
         st_next.active_res = st_reg.step_resolution_sel;       // see (RULE8)
         st_next.phase = ST_STEP;
         // stepping from the current point keeps any offset; finer grids hold it
         if (dir_up) next_pos = 7'(st_reg.pos + stride);       // see (RULE4) see (RULE12)
         else next_pos = 7'(st_reg.pos - stride);              // see (RULE9) see (RULE10) see (RULE11)
      end
      st_next.pos = next_pos;                                  // see (RULE7)
      st_next.cx = map_x;                                      // see (RULE1)
      st_next.cy = map_y;
      // register writes
      if (wr_stb) begin
         case (addr)
            OFS_CTRL0: st_next.step_resolution_sel = wdata[RES_LSB +: 3];
            OFS_CTRL1: begin
               st_next.rotation_sense_bit = wdata[SENSE_BIT];
               st_next.step_edge_polarity = wdata[POL_BIT];
            end
            default: ;
         endcase
      end
      // reads answer next cycle only
      st_next.rdata = 8'h00;
      if (rd_stb) begin
         case (addr)
            OFS_CTRL0:  st_next.rdata = {5'h00, st_reg.step_resolution_sel};
            OFS_CTRL1:  st_next.rdata = {6'h00, st_reg.step_edge_polarity,
                                          st_reg.rotation_sense_bit};
            OFS_POS:    st_next.rdata = {1'b0, st_reg.pos};      // see (RULE6)
            OFS_ACTIVE: st_next.rdata = {5'h00, st_reg.active_res};
            default:    st_next.rdata = 8'h00;
         endcase
      end
   end

   // state register; reset gives fine stepping at zero
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '{step_sync: 2'h0, dir_sync: 2'h0, step_prev: 1'b0,
                     step_resolution_sel: RES_RST, active_res: RES_RST,  // see (RULE13)
                     rotation_sense_bit: CTRL1_RST[SENSE_BIT],
                     step_edge_polarity: CTRL1_RST[POL_BIT],
                     pos: POS_RST, rdata: 8'h00, cx: 11'sd0,
                     cy: CUR_FULL, phase: ST_IDLE};
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata = st_reg.rdata;
   assign coil_x = st_reg.cx;
   assign coil_y = st_reg.cy;
   assign translator_position = st_reg.pos;

   // a step moves exactly one stride in the resolved direction
   AST_STEP_STRIDE: assert property (@(posedge ref_clk) disable iff (!rstn)  // see (RULE4)
      trig |=> (st_reg.pos == 7'($past(st_reg.pos) + ($past(dir_up) ? $past(stride)
                 : 7'(-$past(stride))))))
      else $error("step did not move by one stride");
   // no edge, no move
   AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)  // see (RULE7)
      !trig |=> $stable(st_reg.pos))
      else $error("position moved without a step");
   // resolution change waits for a step
   AST_RES_WAIT: assert property (@(posedge ref_clk) disable iff (!rstn)  // see (RULE8)
      !trig |=> $stable(st_reg.active_res))
      else $error("resolution applied without a step");
   // position read returns the position
   AST_POS_READ: assert property (@(posedge ref_clk) disable iff (!rstn)  // see (RULE6)
      (rd_stb && addr == OFS_POS) |=> (rdata == {1'b0, $past(st_reg.pos)}))
      else $error("position read wrong");
   // rising edge of synchronised input steps when polarity is 0
   AST_POL: assert property (@(posedge ref_clk) disable iff (!rstn)  // see (RULE5)
      (!st_reg.step_edge_polarity && st_reg.step_sync[1] && !st_reg.step_prev) |-> trig)
      else $error("rising edge missed");
   // direction is pin xor control bit
   AST_DIR: assert property (@(posedge ref_clk) disable iff (!rstn)  // see (RULE3)
      (trig && st_reg.dir_sync[1] == st_reg.rotation_sense_bit) |=>
      (st_reg.pos == 7'($past(st_reg.pos) - $past(stride))))
      else $error("direction not inverted by control bit");
   // square modes drive full magnitude on both coils off the axes
   AST_SQUARE: assert property (@(posedge ref_clk) disable iff (!rstn)  // see (RULE14)
      (is_square(st_reg.active_res) && st_reg.pos == 7'h10 && st_reg.phase == ST_STEP)
      |-> (coil_x == CUR_FULL && coil_y == CUR_FULL))
      else $error("square table value wrong");
   // stepping up from 127 in fine mode wraps to 0
   AST_WRAP: assert property (@(posedge ref_clk) disable iff (!rstn)  // see (RULE12)
      (trig && dir_up && stride == 7'h01 && st_reg.pos == 7'h7f) |=> (st_reg.pos == 7'h00))
      else $error("position did not wrap");
endmodule

// file: rtl/translator_pkg.sv
// Purpose: shared constants for the step translator
// Assumes: 100 MHz reference clock, plain register port
// Notes:   currents are signed tenths of a percent of peak current
package translator_pkg;
   localparam int POS_W = 7;
   localparam int CUR_W = 11;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [3:0] OFS_CTRL0 = 4'h0;
   localparam logic [3:0] OFS_CTRL1 = 4'h1;
   localparam logic [3:0] OFS_POS = 4'h2;
   localparam logic [3:0] OFS_ACTIVE = 4'h3;
   // field positions
   localparam int RES_LSB = 0;
   localparam int SENSE_BIT = 0;
   localparam int POL_BIT = 1;
   // reset values
   localparam logic [2:0] RES_RST = 3'h0;
   localparam logic [6:0] POS_RST = 7'h00;
   localparam logic [1:0] CTRL1_RST = 2'h0;
   // resolution codes
   localparam logic [2:0] RES_HALF_SQ = 3'h5;
   localparam logic [2:0] RES_FULL = 3'h6;
   localparam logic [2:0] RES_COARSE_CIRC = 3'h4;
   // full magnitude, 100.0 percent
   localparam logic signed [10:0] CUR_FULL = 11'sd1000;
   // quarter-wave table, positions 0..16, coil x, tenths of percent
   localparam logic [9:0] QTAB [17] = '{
      10'd0, 10'd35, 10'd81, 10'd127, 10'd174, 10'd221, 10'd267, 10'd314,
      10'd349, 10'd383, 10'd430, 10'd465, 10'd500, 10'd546, 10'd581,
      10'd616, 10'd651};
endpackage

// file: rtl/coil_current_map.sv
// Purpose: maps translator position to coil currents
// Assumes: position in 1/32 units, 128 entries per electrical turn
// Notes:   combinational; caller registers the outputs
`timescale 1ns/100ps
module coil_current_map
   import translator_pkg::*;
(
   // position and table shape
   input  wire logic [6:0]        pos,
   input  wire logic              square,
   // currents
   output logic signed [10:0]     cur_x,
   output logic signed [10:0]     cur_y
);
   // circular value from symmetric quarter table
   function automatic logic signed [10:0] circ(input logic [6:0] p);
      logic [5:0] r;
      logic [9:0] m;
      // second half of each half-turn mirrors the first
      r = p[5] ? 6'(6'd32 - {1'b0, p[4:0]}) : {1'b0, p[4:0]};
      if (r <= 6'd16) m = QTAB[r[4:0]];
      else m = cos_mag(5'(6'd32 - r));
      circ = p[6] ? -$signed({1'b0, m}) : $signed({1'b0, m});
   endfunction
   // magnitude of the other coil at mirror position (0..16)
   function automatic logic [9:0] cos_mag(input logic [4:0] k);
      case (k)
         5'd0:    cos_mag = 10'd1000;
         5'd1:    cos_mag = 10'd988;
         5'd2:    cos_mag = 10'd977;
         5'd3:    cos_mag = 10'd965;
         5'd4:    cos_mag = 10'd953;
         5'd5:    cos_mag = 10'd941;
         5'd6:    cos_mag = 10'd930;
         5'd7:    cos_mag = 10'd918;
         5'd8:    cos_mag = 10'd895;
         5'd9:    cos_mag = 10'd872;
         5'd10:   cos_mag = 10'd849;
         5'd11:   cos_mag = 10'd826;
         5'd12:   cos_mag = 10'd790;
         5'd13:   cos_mag = 10'd755;
         5'd14:   cos_mag = 10'd721;
         5'd15:   cos_mag = 10'd686;
         default: cos_mag = 10'd651;
      endcase
   endfunction
   // square table: nonzero coil at full magnitude
   function automatic logic signed [10:0] sq(input logic signed [10:0] v);
      if (v > 11'sd0) sq = CUR_FULL;
      else if (v < 11'sd0) sq = -CUR_FULL;
      else sq = 11'sd0;
   endfunction
   logic signed [10:0] cx;
   logic signed [10:0] cy;
   // y leads x by a quarter turn
   always_comb begin
      cx = circ(pos);
      cy = circ(7'(pos + 7'd32));
      cur_x = square ? sq(cx) : cx;   // see (RULE14)
      cur_y = square ? sq(cy) : cy;   // see (RULE1)
   end
endmodule

// file: tb/step_source.sv
// Purpose: controller model driving the step and direction pins
// Assumes: pins change just after a rising edge of ref_clk
// Notes:   each level is held at least 6 cycles, above the 2-cycle pin minimum
`timescale 1ns/100ps
module step_source (
   // clock
   input  wire logic ref_clk,
   // motion pins
   output logic      step_pulse_in,
   output logic      dir_pin
);
   // idle low, up direction at time zero
   initial begin
      step_pulse_in = 1'b0;
      dir_pin = 1'b1;
   end

   // one pin level, held long enough for sync and edge detect
   task automatic level(input logic v);
      @(posedge ref_clk);
      step_pulse_in <= v;
      repeat (5) @(posedge ref_clk);
   endtask

   // direction settles before any following step edge
   task automatic set_dir(input logic v);
      @(posedge ref_clk);
      dir_pin <= v;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule

// file: tb/tb_microstep_translator.sv
// Purpose: self-checking bench for the step translator
// Assumes: step_source drives the motion pins, bench drives the register port
// Notes:   currents expected from the table, in tenths of a percent
`timescale 1ns/100ps
module tb_microstep_translator
   import translator_pkg::*;
;
   logic                 ref_clk;
   logic                 rstn;
   logic                 step_pulse_in;
   logic                 dir_pin;
   logic [ADDR_W-1:0]    addr;
   logic [DATA_W-1:0]    wdata;
   logic                 wr_stb;
   logic                 rd_stb;
   logic [DATA_W-1:0]    rdata;
   logic signed [CUR_W-1:0] coil_x;
   logic signed [CUR_W-1:0] coil_y;
   logic [POS_W-1:0]     translator_position;
   int                   fail_count;
   int                   checks;

   microstep_translator u_dut (.ref_clk(ref_clk), .rstn(rstn),
      .step_pulse_in(step_pulse_in), .dir_pin(dir_pin), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .coil_x(coil_x), .coil_y(coil_y),
      .translator_position(translator_position));
   step_source u_src (.ref_clk(ref_clk), .step_pulse_in(step_pulse_in), .dir_pin(dir_pin));

   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic give_verdict();
      if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle strobes, rdata sampled in the cycle after the read strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      check({8'h00, d}, {8'h00, e});
   endtask

   // port and register must agree with the expected position
   task automatic chk_pos(input logic [6:0] e);
      check({9'h000, translator_position}, {9'h000, e});
      rd_chk(OFS_POS, {1'b0, e});
   endtask

   task automatic chk_coil(input logic [10:0] ex, input logic [10:0] ey);
      check({5'h00, coil_x}, {5'h00, ex});
      check({5'h00, coil_y}, {5'h00, ey});
   endtask

   task automatic step();
      u_src.level(1'b1);
      u_src.level(1'b0);
   endtask

   task automatic t_reset();
      chk_pos(7'h00);
      chk_coil(11'h000, 11'h3e8);
      rd_chk(OFS_CTRL0, 8'h00);
      rd_chk(OFS_CTRL1, 8'h00);
      // read data stands one cycle only, then returns to zero
      @(posedge ref_clk);
      #1 check({8'h00, rdata}, 16'h0000);
      rd_chk(OFS_ACTIVE, 8'h00);
      wr(4'hf, 8'hff);
      rd_chk(4'hf, 8'h00);
   endtask

   // step down below zero and back up
   task automatic t_wrap();
      u_src.set_dir(1'b0);
      step();
      chk_pos(7'h7f);
      chk_coil(11'h7dd, 11'h3dc);
      u_src.set_dir(1'b1);
      step();
      chk_pos(7'h00);
   endtask

   // codes 0..4 each applied only at the next step; off-grid offset kept
   task automatic t_strides();
      logic [6:0] e;
      e = 7'h00;
      for (int c = 0; c < 5; c++) begin
         wr(OFS_CTRL0, 8'(c));
         rd_chk(OFS_ACTIVE, 8'(c == 0 ? 0 : c - 1));
         step();
         e = e + 7'(1 << c);
         chk_pos(e);
         rd_chk(OFS_ACTIVE, 8'(c));
      end
   endtask

   // shared position then finer grid
   task automatic t_grid();
      wr(OFS_CTRL0, 8'h00);
      step();
      chk_coil(11'h3e8, 11'h000);
      wr(OFS_CTRL0, 8'h04);
      step();
      chk_pos(7'h30);
      chk_coil(11'h28b, 11'h575);
      wr(OFS_CTRL0, 8'h01);
      step();
      chk_pos(7'h32);
   endtask

   // sense bit inverts the pin
   task automatic t_sense();
      wr(OFS_CTRL0, 8'h00);
      wr(OFS_CTRL1, 8'h01);
      step();
      chk_pos(7'h31);
      u_src.set_dir(1'b0);
      step();
      chk_pos(7'h32);
      wr(OFS_CTRL1, 8'h00);
      u_src.set_dir(1'b1);
   endtask

   // falling edge only moves the translator
   task automatic t_polarity();
      wr(OFS_CTRL1, 8'h02);
      u_src.level(1'b1);
      chk_pos(7'h32);
      u_src.level(1'b0);
      chk_pos(7'h33);
      wr(OFS_CTRL1, 8'h00);
   endtask

   // square table for full and uncompensated half step
   task automatic t_square();
      wr(OFS_CTRL0, {5'h00, RES_FULL});
      step();
      chk_pos(7'h53);
      chk_coil(11'h418, 11'h418);
      wr(OFS_CTRL0, {5'h00, RES_HALF_SQ});
      step();
      chk_pos(7'h63);
      chk_coil(11'h418, 11'h3e8);
   endtask

   // reset in mid-run must bring back fine stepping at zero
   task automatic t_midreset();
      @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk_coil(11'h000, 11'h3e8);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk_pos(7'h00);
      rd_chk(OFS_ACTIVE, 8'h00);
      rd_chk(OFS_CTRL0, 8'h00);
      step();
      chk_pos(7'h01);
   endtask

   // watchdog, well beyond the expected few hundred cycles
   initial begin
      #200000;
      fail_count++;
      give_verdict();
   end

   initial begin
      fail_count = 0;
      checks = 0;
      rstn = 1'b0;
      addr = '0;
      wdata = '0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_reset();
      t_wrap();
      t_strides();
      t_grid();
      t_sense();
      t_polarity();
      t_square();
      t_midreset();
      give_verdict();
   end
endmodule
